// file: hw/pmx_pkg.sv
// Constants, register map and carrier types for the port and pin-mux block
package pmx_pkg;

    // Pin counts
    localparam int D_IO_PINS = 10;
    localparam int D_IN_PINS = 2;
    localparam int R_PORTS   = 5;
    localparam int R_IO_BITS = 20;
    localparam int R_IN_PINS = 6;

    // Memory-mapped register offsets (nibble registers)
    localparam logic [5:0] ADDR_PORT_MODE_A   = 6'h04;
    localparam logic [5:0] ADDR_MISC_PULL     = 6'h0c;
    localparam logic [5:0] ADDR_PORT_MODE_B   = 6'h24;
    localparam logic [5:0] ADDR_PORT_MODE_C   = 6'h25;
    localparam logic [5:0] ADDR_D_DRIVE_CTRL0 = 6'h2c;
    localparam logic [5:0] ADDR_D_DRIVE_CTRL1 = 6'h2d;
    localparam logic [5:0] ADDR_D_DRIVE_CTRL2 = 6'h2e;
    localparam logic [5:0] ADDR_R_DRIVE_CTRL0 = 6'h30;
    localparam logic [5:0] ADDR_R_DRIVE_CTRL4 = 6'h34;

    // Reset values and read masks
    localparam logic [3:0] NIB_RESET    = 4'h0;
    localparam logic [3:0] D_DC2_MASK   = 4'h3;

    // Field positions
    localparam int PULL_GLOBAL_BIT      = 3;
    localparam int IRQ1_SEL_BIT         = 0;
    localparam int EVENT_SEL_BIT        = 1;
    localparam int STOP_CANCEL_SEL_BIT  = 2;
    localparam int IRQ0_SEL_BIT         = 3;
    localparam int SERIAL_SEL_LO_BIT    = 0;
    localparam int SERIAL_SEL_HI_BIT    = 1;

    // Port indices used by the nibble read/write instructions
    localparam logic [3:0] R_IDX_C = 4'hc;
    localparam logic [3:0] R_IDX_D = 4'hd;
    localparam logic [3:0] R_IDX_E = 4'he;

    // Bit indices of the two input-only D pins
    localparam logic [3:0] D_BIT_STOP_CANCEL_IN = 4'hc;
    localparam logic [3:0] D_BIT_IRQ0  = 4'hd;

    // Flat R pin positions (port * 4 + bit)
    localparam int R_POS_IRQ1  = 0;
    localparam int R_POS_TOC   = 13;
    localparam int R_POS_TOD   = 14;
    localparam int R_POS_EVENT = 16;
    localparam int R_POS_SCLK  = 17;
    localparam int R_POS_SIN   = 18;
    localparam int R_POS_SOUT  = 19;

    // D pin groups
    localparam int D_PULL_DN_LAST = 3;
    localparam int D_OD_FIRST     = 4;
    localparam int D_OD_LAST      = 7;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [3:0] wdata;
    } pmx_mem_req_t;

    typedef struct packed {
        logic       d_set;
        logic       d_clr;
        logic       d_test;
        logic [3:0] d_bit;
        logic       r_wr;
        logic       r_rd;
        logic [3:0] r_idx;
        logic [3:0] r_wdata;
    } pmx_port_req_t;

    // From the peripherals to the pin mux
    typedef struct packed {
        logic [2:0] timer_c_output_mode;
        logic [3:0] timer_d_output_mode;
        logic       timer_c_out;
        logic       timer_d_out;
        logic       serial_clock_pin_select;
        logic       serial_clk_drive;
        logic       serial_clk_out;
        logic       serial_out1;
        logic       comparator_pin_select;
    } pmx_periph_out_t;

    // From the pins to the peripherals
    typedef struct packed {
        logic stop_cancel_in;
        logic ext_irq0_in;
        logic ext_irq1_in;
        logic event_count_in;
        logic serial_clk1;
        logic serial_in1;
        logic compare_in0;
        logic compare_in1;
    } pmx_periph_in_t;

    typedef struct packed {
        logic [3:0]                          port_mode_a;
        logic [3:0]                          misc_pull_control;
        logic [3:0]                          port_mode_b;
        logic [3:0]                          port_mode_c;
        logic [D_IO_PINS-1:0]                d_drive_ctrl;
        logic [R_IO_BITS-1:0]                r_drive_ctrl;
        logic [D_IO_PINS-1:0]                d_latch;
        logic [R_IO_BITS-1:0]                r_latch;
        logic [D_IO_PINS+D_IN_PINS-1:0]      d_sync1;
        logic [D_IO_PINS+D_IN_PINS-1:0]      d_sync2;
        logic [R_IO_BITS+R_IN_PINS-1:0]      r_sync1;
        logic [R_IO_BITS+R_IN_PINS-1:0]      r_sync2;
        logic [3:0]                          mem_rdata;
        logic                                d_test_result;
        logic [3:0]                          r_rdata;
        logic [D_IO_PINS-1:0]                d_pin_out;
        logic [D_IO_PINS-1:0]                d_pin_oe_n;
        logic [D_IO_PINS-1:0]                d_pull_up_on;
        logic [D_IO_PINS-1:0]                d_pull_dn_on;
        logic [R_IO_BITS-1:0]                r_pin_out;
        logic [R_IO_BITS-1:0]                r_pin_oe_n;
        logic [R_IO_BITS-1:0]                r_pull_on;
        pmx_periph_in_t                      periph;
        logic                                halt_signal;
    } pmx_state_t;

endpackage

// file: hw/pmx_port_io.sv
// D and R port pins with drive control, pull control and peripheral pin mux
//
// What this block does
// - D drive-control bit gates both output transistors
// - Latch 1 drives high side, 0 low side
// - Five R drive-control registers gate R outputs
// - Global pull enable plus latch 1 turns pull on
// - D0-D3 pull-down, other I/O pins pull-up
// - Pull control independent of peripheral selection
// - Ten D I/O bits set/cleared singly, two inputs
// - Bit test samples every D pin level
// - Input-only D pins feed stop-cancel and irq0
// - R ports read and written four bits wide
// - Missing R bits may read undefined
// - Port mode B bit0 routes R0_0 to irq1
// - Timer output modes take two R3 pins
// - Port mode C bit1 routes R4_0 to event
// - Serial selects route upper R4 pins
// - Comparator select takes two lowest RD pins
// - Stop resets selections, drops halt, floats pins
// - Variant: D4-D7 open-drain outputs, no pulls
// - Peripheral selection overrides port direction and data
`timescale 1ns/1ns
`default_nettype none

module pmx_port_io
    import pmx_pkg::*;
#(
    parameter bit                 OPEN_DRAIN_VARIANT = 1'b0,
    parameter logic [R_IO_BITS-1:0] R_PIN_PRESENT    = 20'hf73ff
) (
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    input  wire logic                              stop_mode,
    input  wire pmx_mem_req_t                      mem_req,
    output logic [3:0]                             mem_rdata,
    input  wire pmx_port_req_t                     port_req,
    output logic                                   d_test_result,
    output logic [3:0]                             r_rdata,
    input  wire pmx_periph_out_t                   periph_out,
    output pmx_periph_in_t                         periph_in,
    output logic                                   halt_signal,
    input  wire logic [D_IO_PINS+D_IN_PINS-1:0]    d_pin_in,
    output logic [D_IO_PINS-1:0]                   d_pin_out,
    output logic [D_IO_PINS-1:0]                   d_pin_oe_n,
    output logic [D_IO_PINS-1:0]                   d_pull_up_on,
    output logic [D_IO_PINS-1:0]                   d_pull_dn_on,
    input  wire logic [R_IO_BITS+R_IN_PINS-1:0]    r_pin_in,
    output logic [R_IO_BITS-1:0]                   r_pin_out,
    output logic [R_IO_BITS-1:0]                   r_pin_oe_n,
    output logic [R_IO_BITS-1:0]                   r_pull_on
);

    pmx_state_t st_r;
    pmx_state_t st_nxt;

    always_comb begin
        logic       pull_en;
        logic       od_pin;
        logic [3:0] nib;
        pull_en = 1'b0;
        od_pin  = 1'b0;
        nib     = NIB_RESET;
        st_nxt  = st_r;

        // Two-stage synchronisers on every pin input
        st_nxt.d_sync1 = d_pin_in;
        st_nxt.d_sync2 = st_r.d_sync1;
        st_nxt.r_sync1 = r_pin_in;
        st_nxt.r_sync2 = st_r.r_sync1;

        // Register writes at their memory addresses
        if (mem_req.wr) begin
            if (mem_req.addr == ADDR_PORT_MODE_A) begin
                st_nxt.port_mode_a = mem_req.wdata;
            end else if (mem_req.addr == ADDR_MISC_PULL) begin
                st_nxt.misc_pull_control = mem_req.wdata;
            end else if (mem_req.addr == ADDR_PORT_MODE_B) begin
                st_nxt.port_mode_b = mem_req.wdata;
            end else if (mem_req.addr == ADDR_PORT_MODE_C) begin
                st_nxt.port_mode_c = mem_req.wdata;
            end else if (mem_req.addr == ADDR_D_DRIVE_CTRL0) begin
                st_nxt.d_drive_ctrl[3:0] = mem_req.wdata;
            end else if (mem_req.addr == ADDR_D_DRIVE_CTRL1) begin
                st_nxt.d_drive_ctrl[7:4] = mem_req.wdata;
            end else if (mem_req.addr == ADDR_D_DRIVE_CTRL2) begin
                st_nxt.d_drive_ctrl[9:8] = mem_req.wdata[1:0];
            end else begin
                for (int k = 0; k < R_PORTS; k++) begin
                    if (mem_req.addr == ADDR_R_DRIVE_CTRL0 + 6'(k)) begin
                        st_nxt.r_drive_ctrl[4*k +: 4] = mem_req.wdata;
                    end
                end
            end
        end

        // Register reads; unmapped addresses answer zero
        if (mem_req.rd) begin
            if (mem_req.addr == ADDR_PORT_MODE_A) begin
                st_nxt.mem_rdata = st_r.port_mode_a;
            end else if (mem_req.addr == ADDR_MISC_PULL) begin
                st_nxt.mem_rdata = st_r.misc_pull_control;
            end else if (mem_req.addr == ADDR_PORT_MODE_B) begin
                st_nxt.mem_rdata = st_r.port_mode_b;
            end else if (mem_req.addr == ADDR_PORT_MODE_C) begin
                st_nxt.mem_rdata = st_r.port_mode_c;
            end else if (mem_req.addr == ADDR_D_DRIVE_CTRL0) begin
                st_nxt.mem_rdata = st_r.d_drive_ctrl[3:0];
            end else if (mem_req.addr == ADDR_D_DRIVE_CTRL1) begin
                st_nxt.mem_rdata = st_r.d_drive_ctrl[7:4];
            end else if (mem_req.addr == ADDR_D_DRIVE_CTRL2) begin
                st_nxt.mem_rdata = {2'b00, st_r.d_drive_ctrl[9:8]} & D_DC2_MASK;
            end else begin
                st_nxt.mem_rdata = NIB_RESET;
                for (int k = 0; k < R_PORTS; k++) begin
                    if (mem_req.addr == ADDR_R_DRIVE_CTRL0 + 6'(k)) begin
                        st_nxt.mem_rdata = st_r.r_drive_ctrl[4*k +: 4];
                    end
                end
            end
        end

        // Single-bit D latch update; set takes priority if both arrive
        for (int i = 0; i < D_IO_PINS; i++) begin
            if (port_req.d_bit == 4'(i)) begin
                if (port_req.d_set) begin
                    st_nxt.d_latch[i] = 1'b1;
                end else if (port_req.d_clr) begin
                    st_nxt.d_latch[i] = 1'b0;
                end
            end
        end

        // Bit test sees the pin level, input-only pins included
        if (port_req.d_test) begin
            st_nxt.d_test_result = 1'b0;
            for (int i = 0; i < D_IO_PINS; i++) begin
                if (port_req.d_bit == 4'(i)) begin
                    st_nxt.d_test_result = st_r.d_sync2[i];
                end
            end
            if (port_req.d_bit == D_BIT_STOP_CANCEL_IN) begin
                st_nxt.d_test_result = st_r.d_sync2[D_IO_PINS];
            end else if (port_req.d_bit == D_BIT_IRQ0) begin
                st_nxt.d_test_result = st_r.d_sync2[D_IO_PINS+1];
            end
        end

        // Nibble-wide R port write and read
        for (int k = 0; k < R_PORTS; k++) begin
            if (port_req.r_wr && port_req.r_idx == 4'(k)) begin
                st_nxt.r_latch[4*k +: 4] = port_req.r_wdata;
            end
        end
        if (port_req.r_rd) begin
            // Missing bit positions read as zero, which the CPU may not rely on
            st_nxt.r_rdata = NIB_RESET;
            for (int k = 0; k < R_PORTS; k++) begin
                if (port_req.r_idx == 4'(k)) begin
                    st_nxt.r_rdata = st_r.r_sync2[4*k +: 4] & R_PIN_PRESENT[4*k +: 4];
                end
            end
            if (port_req.r_idx == R_IDX_C) begin
                st_nxt.r_rdata = {3'b000, st_r.r_sync2[R_IO_BITS]};
            end else if (port_req.r_idx == R_IDX_D) begin
                nib = st_r.r_sync2[R_IO_BITS+1 +: 4];
                if (periph_out.comparator_pin_select) begin
                    nib[1:0] = 2'b00;
                end
                st_nxt.r_rdata = nib;
            end else if (port_req.r_idx == R_IDX_E) begin
                st_nxt.r_rdata = {3'b000, st_r.r_sync2[R_IO_BITS+5]};
            end
        end

        // D pin drivers and pulls
        pull_en = st_r.misc_pull_control[PULL_GLOBAL_BIT];
        for (int i = 0; i < D_IO_PINS; i++) begin
            od_pin = OPEN_DRAIN_VARIANT && i >= D_OD_FIRST && i <= D_OD_LAST;
            if (od_pin) begin
                // Open-drain pins only ever sink, and have no pull device
                st_nxt.d_pin_out[i]    = 1'b0;
                st_nxt.d_pin_oe_n[i]   = ~(st_r.d_drive_ctrl[i] & ~st_r.d_latch[i]);
                st_nxt.d_pull_up_on[i] = 1'b0;
                st_nxt.d_pull_dn_on[i] = 1'b0;
            end else begin
                st_nxt.d_pin_out[i]  = st_r.d_latch[i];
                st_nxt.d_pin_oe_n[i] = ~st_r.d_drive_ctrl[i];
                if (i <= D_PULL_DN_LAST) begin
                    st_nxt.d_pull_up_on[i] = 1'b0;
                    st_nxt.d_pull_dn_on[i] = pull_en & st_r.d_latch[i];
                end else begin
                    st_nxt.d_pull_up_on[i] = pull_en & st_r.d_latch[i];
                    st_nxt.d_pull_dn_on[i] = 1'b0;
                end
            end
        end

        // R pin drivers and pulls; pulls ignore peripheral selection
        for (int j = 0; j < R_IO_BITS; j++) begin
            st_nxt.r_pin_out[j]  = st_r.r_latch[j];
            st_nxt.r_pin_oe_n[j] = ~(st_r.r_drive_ctrl[j] & R_PIN_PRESENT[j]);
            st_nxt.r_pull_on[j]  = pull_en & st_r.r_latch[j] & R_PIN_PRESENT[j];
        end

        // Peripheral selections override the port settings of their pins
        if (st_r.port_mode_b[IRQ1_SEL_BIT]) begin
            st_nxt.r_pin_oe_n[R_POS_IRQ1] = 1'b1;
        end
        if (periph_out.timer_c_output_mode != 3'h0) begin
            st_nxt.r_pin_out[R_POS_TOC]  = periph_out.timer_c_out;
            st_nxt.r_pin_oe_n[R_POS_TOC] = 1'b0;
        end
        if (periph_out.timer_d_output_mode != 4'h0) begin
            st_nxt.r_pin_out[R_POS_TOD]  = periph_out.timer_d_out;
            st_nxt.r_pin_oe_n[R_POS_TOD] = 1'b0;
        end
        if (st_r.port_mode_c[EVENT_SEL_BIT]) begin
            st_nxt.r_pin_oe_n[R_POS_EVENT] = 1'b1;
        end
        if (periph_out.serial_clock_pin_select) begin
            st_nxt.r_pin_out[R_POS_SCLK]  = periph_out.serial_clk_out;
            st_nxt.r_pin_oe_n[R_POS_SCLK] = ~periph_out.serial_clk_drive;
        end
        if (st_r.port_mode_a[SERIAL_SEL_LO_BIT]) begin
            st_nxt.r_pin_oe_n[R_POS_SIN] = 1'b1;
        end
        if (st_r.port_mode_a[SERIAL_SEL_HI_BIT]) begin
            st_nxt.r_pin_out[R_POS_SOUT]  = periph_out.serial_out1;
            st_nxt.r_pin_oe_n[R_POS_SOUT] = 1'b0;
        end

        // Pin levels to peripherals; deselected inputs rest inactive
        // Stop-cancel stays routed in stop mode, else the device could never wake
        st_nxt.periph.stop_cancel_in = (st_r.port_mode_c[STOP_CANCEL_SEL_BIT] || stop_mode)
                                       ? st_r.d_sync2[D_IO_PINS] : 1'b1;
        st_nxt.periph.ext_irq0_in    = st_r.port_mode_c[IRQ0_SEL_BIT]
                                       ? st_r.d_sync2[D_IO_PINS+1] : 1'b1;
        st_nxt.periph.ext_irq1_in    = st_r.port_mode_b[IRQ1_SEL_BIT]
                                       ? st_r.r_sync2[R_POS_IRQ1] : 1'b1;
        st_nxt.periph.event_count_in = st_r.port_mode_c[EVENT_SEL_BIT]
                                       ? st_r.r_sync2[R_POS_EVENT] : 1'b0;
        st_nxt.periph.serial_clk1    = periph_out.serial_clock_pin_select
                                       ? st_r.r_sync2[R_POS_SCLK] : 1'b1;
        st_nxt.periph.serial_in1     = st_r.port_mode_a[SERIAL_SEL_LO_BIT]
                                       ? st_r.r_sync2[R_POS_SIN] : 1'b0;
        st_nxt.periph.compare_in0    = periph_out.comparator_pin_select
                                       ? st_r.r_sync2[R_IO_BITS+1] : 1'b0;
        st_nxt.periph.compare_in1    = periph_out.comparator_pin_select
                                       ? st_r.r_sync2[R_IO_BITS+2] : 1'b0;

        st_nxt.halt_signal = 1'b1;

        // Stop mode clears the mode, pull and drive-control registers and floats all pins; the D and R latches keep their values
        if (stop_mode) begin
            st_nxt.port_mode_a       = NIB_RESET;
            st_nxt.port_mode_b       = NIB_RESET;
            st_nxt.port_mode_c       = NIB_RESET;
            st_nxt.misc_pull_control = NIB_RESET;
            st_nxt.d_drive_ctrl      = '0;
            st_nxt.r_drive_ctrl      = '0;
            st_nxt.d_pin_oe_n        = '1;
            st_nxt.r_pin_oe_n        = '1;
            st_nxt.d_pull_up_on      = '0;
            st_nxt.d_pull_dn_on      = '0;
            st_nxt.r_pull_on         = '0;
            st_nxt.halt_signal       = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_r                   <= '0;
            st_r.d_pin_oe_n        <= '1;
            st_r.r_pin_oe_n        <= '1;
            st_r.periph.stop_cancel_in <= 1'b1;
            st_r.periph.ext_irq0_in    <= 1'b1;
            st_r.periph.ext_irq1_in    <= 1'b1;
            st_r.periph.serial_clk1    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mem_rdata     = st_r.mem_rdata;
    assign d_test_result = st_r.d_test_result;
    assign r_rdata       = st_r.r_rdata;
    assign periph_in     = st_r.periph;
    assign halt_signal   = st_r.halt_signal;
    assign d_pin_out     = st_r.d_pin_out;
    assign d_pin_oe_n    = st_r.d_pin_oe_n;
    assign d_pull_up_on  = st_r.d_pull_up_on;
    assign d_pull_dn_on  = st_r.d_pull_dn_on;
    assign r_pin_out     = st_r.r_pin_out;
    assign r_pin_oe_n    = st_r.r_pin_oe_n;
    assign r_pull_on     = st_r.r_pull_on;

endmodule

`default_nettype wire

// file: verif/pmx_pin_model.sv
// Outside circuitry on the port pins
`timescale 1ns/1ns
`default_nettype none
module pmx_pin_model
    import pmx_pkg::*;
(
    input  wire logic [D_IO_PINS-1:0]           d_pin_out,
    input  wire logic [D_IO_PINS-1:0]           d_pin_oe_n,
    input  wire logic [D_IO_PINS-1:0]           d_pull_up_on,
    input  wire logic [D_IO_PINS-1:0]           d_pull_dn_on,
    input  wire logic [R_IO_BITS-1:0]           r_pin_out,
    input  wire logic [R_IO_BITS-1:0]           r_pin_oe_n,
    input  wire logic [R_IO_BITS-1:0]           r_pull_on,
    input  wire logic [D_IO_PINS+D_IN_PINS-1:0] ext_d,
    input  wire logic [R_IO_BITS+R_IN_PINS-1:0] ext_r,
    output logic [D_IO_PINS+D_IN_PINS-1:0]      d_pin_in,
    output logic [R_IO_BITS+R_IN_PINS-1:0]      r_pin_in
);
    // Outside sources are resistive, so a driven or pulled pin follows the chip
    assign d_pin_in = {ext_d[11:10], (~d_pin_oe_n & d_pin_out)
                       | (d_pin_oe_n & (d_pull_up_on | (~d_pull_dn_on & ext_d[9:0])))};
    // The reference pin carries plain logic levels only
    assign r_pin_in = {ext_r[25:20], (~r_pin_oe_n & r_pin_out)
                       | (r_pin_oe_n & (r_pull_on | ext_r[19:0]))};
endmodule
`default_nettype wire

// file: verif/pmx_port_io_props.sv
// Concurrent checks on the pins of the port and pin-mux block
`timescale 1ns/1ns
`default_nettype none
module pmx_port_io_props
    import pmx_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire logic                 stop_mode,
    input wire pmx_mem_req_t         mem_req,
    input wire logic [3:0]           mem_rdata,
    input wire pmx_port_req_t        port_req,
    input wire logic [3:0]           r_rdata,
    input wire pmx_periph_out_t      periph_out,
    input wire logic                 halt_signal,
    input wire logic [D_IO_PINS-1:0] d_pin_out,
    input wire logic [D_IO_PINS-1:0] d_pin_oe_n,
    input wire logic [D_IO_PINS-1:0] d_pull_up_on,
    input wire logic [D_IO_PINS-1:0] d_pull_dn_on,
    input wire logic [R_IO_BITS-1:0] r_pin_out,
    input wire logic [R_IO_BITS-1:0] r_pin_oe_n
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Registers clear and pins float together on the first stop edge
    sequence stop_held;
        stop_mode [*3];
    endsequence
    sequence set_d5;
        port_req.d_set && port_req.d_bit == 4'h5 && !stop_mode ##1 !stop_mode [*2];
    endsequence
    a_dc2_upper_zero: assert property (
        mem_req.rd && mem_req.addr == ADDR_D_DRIVE_CTRL2 |=> mem_rdata[3:2] == 2'h0)
        else $error("drive control 2 upper bits not zero");
    a_set_reaches_pin: assert property (
        set_d5 |-> d_pin_out[5])
        else $error("set of pin 5 not seen on its output");
    a_pull_groups: assert property (
        d_pull_up_on[3:0] == 4'h0 && d_pull_dn_on[9:4] == 6'h0)
        else $error("pull of the wrong kind switched on");
    a_timer_c_pin: assert property (
        periph_out.timer_c_output_mode != 3'h0 && !stop_mode |=> !r_pin_oe_n[R_POS_TOC]
        && r_pin_out[R_POS_TOC] == $past(periph_out.timer_c_out))
        else $error("timer c output not on its pin");
    a_stop_floats: assert property (
        stop_held |-> &d_pin_oe_n && &r_pin_oe_n && d_pull_up_on == '0 && d_pull_dn_on == '0)
        else $error("pins not floating in stop");
    // Sampled rst_n skips the edge after release, where halt is still low
    a_halt_high: assert property (
        rst_n && !stop_mode ##1 !stop_mode |-> halt_signal)
        else $error("halt low outside stop");
    a_halt_drops: assert property (
        stop_mode |=> !halt_signal)
        else $error("halt high in stop");
    a_comp_masks: assert property (
        port_req.r_rd && port_req.r_idx == R_IDX_D && periph_out.comparator_pin_select
        |=> r_rdata[1:0] == 2'h0)
        else $error("comparator pins read as port bits");
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the port and pin-mux block
`timescale 1ns/1ns
`default_nettype none
module testbench
    import pmx_pkg::*;
;
    localparam logic [19:0] PRES = 20'hf73ff;
    logic clock, rst_n, stop_mode, d_test_result, halt_signal;
    pmx_mem_req_t mem_req;
    pmx_port_req_t port_req;
    pmx_periph_out_t periph_out;
    pmx_periph_in_t periph_in;
    logic [3:0] mem_rdata, r_rdata, rexp;
    logic [9:0] d_pin_out, d_pin_oe_n, d_pull_up_on, d_pull_dn_on, pat;
    logic [19:0] r_pin_out, r_pin_oe_n, r_pull_on, rp;
    logic [11:0] d_pin_in, ext_d;
    logic [25:0] r_pin_in, ext_r;
    logic [5:0] regs [12] = '{6'h04, 6'h0c, 6'h24, 6'h25, 6'h2c, 6'h2d, 6'h2e,
                              6'h30, 6'h31, 6'h32, 6'h33, 6'h34};
    int num_errors, checks;
    pmx_port_io #(.R_PIN_PRESENT(PRES)) dut (.clock, .rst_n, .stop_mode, .mem_req,
        .mem_rdata, .port_req, .d_test_result, .r_rdata, .periph_out, .periph_in,
        .halt_signal, .d_pin_in, .d_pin_out, .d_pin_oe_n, .d_pull_up_on, .d_pull_dn_on,
        .r_pin_in, .r_pin_out, .r_pin_oe_n, .r_pull_on);
    pmx_pin_model pins (.d_pin_out, .d_pin_oe_n, .d_pull_up_on, .d_pull_dn_on,
        .r_pin_out, .r_pin_oe_n, .r_pull_on, .ext_d, .ext_r, .d_pin_in, .r_pin_in);
    task automatic chk_pin(input logic [29:0] got, input logic [29:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [3:0] got, input logic [3:0] exp);
        chk_pin({26'h0, got}, {26'h0, exp});
    endtask
    task automatic mem(input logic w, input logic [5:0] a, input logic [3:0] d);
        @(posedge clock);
        mem_req <= '{w, !w, a, d};
        @(posedge clock);
        mem_req <= '0;
        @(negedge clock);
    endtask
    task automatic prt(input pmx_port_req_t p);
        @(posedge clock);
        port_req <= p;
        @(posedge clock);
        port_req <= '0;
        @(negedge clock);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        finish_test();
    end
    initial begin
        {num_errors, checks, rst_n, stop_mode, mem_req, port_req, periph_out} = '0;
        {ext_d, ext_r, pat, rp} = {12'h400, 26'h2a10000, 10'h2a5, 20'h0};
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        chk_pin({d_pin_oe_n, r_pin_oe_n}, '1);
        foreach (regs[i]) begin
            mem(0, regs[i], 4'h0);
            chk_reg(mem_rdata, 4'h0);
            mem(1, regs[i], 4'hf);
            mem(0, regs[i], 4'h0);
            chk_reg(mem_rdata, (regs[i] == ADDR_D_DRIVE_CTRL2) ? D_DC2_MASK : 4'hf);
            mem(1, regs[i], 4'h0);
        end
        mem(1, 6'h01, 4'hf);
        mem(0, 6'h01, 4'h0);
        chk_reg(mem_rdata, 4'h0);
        $display("test registers done");
        for (int i = 0; i < 10; i++) prt({pat[i], !pat[i], 1'b0, 4'(i), 10'h0});
        prt({3'b100, 4'ha, 10'h0});
        for (int i = 0; i < 3; i++) mem(1, regs[4 + i], 4'hf);
        @(negedge clock);
        chk_pin({d_pin_oe_n, d_pin_out, 10'h0}, {10'h0, pat, 10'h0});
        mem(1, ADDR_MISC_PULL, 4'h8);
        for (int i = 0; i < 3; i++) mem(1, regs[4 + i], 4'h0);
        @(negedge clock);
        chk_pin({d_pin_oe_n, d_pull_up_on, d_pull_dn_on},
                {10'h3ff, pat & 10'h3f0, pat & 10'h00f});
        repeat (3) @(negedge clock);
        for (int i = 0; i < 16; i++) begin
            prt({3'b001, 4'(i), 10'h0});
            chk_pin({29'h0, d_test_result}, {29'h0, (i < 10) ? (i > 3 && pat[i]) : (i == 12)});
        end
        mem(1, ADDR_MISC_PULL, 4'h0);
        $display("test d port done");
        for (int i = 0; i < 5; i++) begin
            rp[i*4 +: 4] = 4'h9 ^ 4'(i);
            prt({7'h0, 2'b10, 4'(i), 4'h9 ^ 4'(i)});
            mem(1, regs[7 + i], 4'hf);
        end
        @(negedge clock);
        chk_pin({10'h0, r_pin_out & PRES}, {10'h0, rp & PRES});
        chk_pin({10'h0, r_pin_oe_n & PRES}, 30'h0);
        mem(1, ADDR_MISC_PULL, 4'h8);
        @(negedge clock);
        chk_pin({10'h0, r_pull_on}, {10'h0, rp & PRES});
        mem(1, ADDR_MISC_PULL, 4'h0);
        repeat (3) @(negedge clock);
        for (int j = 0; j < 8; j++) begin
            rexp = (j < 5) ? (rp[j*4 +: 4] & PRES[j*4 +: 4]) : 4'(12'h051 >> (4 * (7 - j)));
            prt({7'h0, 2'b01, 4'(j < 5 ? j : j + 7), 4'h0});
            chk_reg(r_rdata, rexp);
        end
        @(posedge clock);
        periph_out.comparator_pin_select <= 1'b1;
        prt({7'h0, 2'b01, R_IDX_D, 4'h0});
        chk_reg(r_rdata, 4'h4);
        $display("test r port done");
        ext_d = 12'h000;
        @(posedge clock);
        periph_out <= '{3'h1, 4'h2, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        mem(1, ADDR_PORT_MODE_A, 4'h2);
        mem(1, ADDR_PORT_MODE_B, 4'h1);
        mem(1, ADDR_PORT_MODE_C, 4'he);
        repeat (5) @(negedge clock);
        chk_pin({20'h0, r_pin_oe_n[0], r_pin_oe_n[16], r_pin_oe_n[13], r_pin_oe_n[14],
                 r_pin_oe_n[19], r_pin_out[13], r_pin_out[14], r_pin_out[19],
                 r_pin_oe_n[17], r_pin_out[17]},
                {20'h0, 10'b1100001001});
        chk_pin({26'h0, periph_in.ext_irq1_in, periph_in.event_count_in, periph_in.ext_irq0_in,
                 periph_in.stop_cancel_in}, {26'h0, 4'b0100});
        $display("test peripherals done");
        @(posedge clock);
        stop_mode <= 1'b1;
        periph_out <= '0;
        repeat (3) @(negedge clock);
        chk_pin({d_pin_oe_n, r_pin_oe_n}, '1);
        chk_pin({29'h0, halt_signal}, 30'h0);
        @(posedge clock);
        stop_mode <= 1'b0;
        mem(0, ADDR_PORT_MODE_C, 4'h0);
        chk_reg(mem_rdata, 4'h0);
        $display("test stop done");
        finish_test();
    end
endmodule
bind pmx_port_io pmx_port_io_props props (.clock, .rst_n, .stop_mode, .mem_req, .mem_rdata,
    .port_req, .r_rdata, .periph_out, .halt_signal, .d_pin_out, .d_pin_oe_n, .d_pull_up_on,
    .d_pull_dn_on, .r_pin_out, .r_pin_oe_n);
`default_nettype wire
